//--- common/pm_timer_pkg.sv
// Constants shared by the power management timer block
package pm_timer_pkg;
	localparam int COUNT_WIDTH = 24;
	localparam int BYTE_WIDTH = 8;
	localparam int IO_ADDR_WIDTH = 16;
	// Reference clock figure in hertz, and the local clock it is sampled with
	localparam int REF_CLOCK_HZ = 3579545;
	localparam int SYS_CLOCK_HZ = 25000000;
	// Local clocks per reference period, rounded down; must stay above 2 for edge sampling
	localparam int REF_PERIOD_CYCLES = SYS_CLOCK_HZ / REF_CLOCK_HZ;
	// Byte offsets from the power management I/O base
	localparam logic [15:0] OFFSET_COUNT_LOW = 16'h0008;
	localparam logic [15:0] OFFSET_COUNT_MID = 16'h0009;
	localparam logic [15:0] OFFSET_COUNT_HIGH = 16'h000A;
	// Field positions of the count bytes
	localparam int COUNT_LOW_LSB = 0;
	localparam int COUNT_MID_LSB = 8;
	localparam int COUNT_HIGH_LSB = 16;
	localparam int COUNT_MSB = 23;
	// Reset values
	localparam logic [23:0] COUNT_RESET = 24'h000000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// Synchroniser input positions and number of synchronised inputs
	localparam int SYNC_REF = 0;
	localparam int SYNC_WORK = 1;
	localparam int SYNC_COUNT = 2;
endpackage

//--- common/timer_core_if.sv
// Carrier between the timer control logic and the counter core
`timescale 1ns/1ns
interface timer_core_if #(parameter int WIDTH = 24);
	logic tick;
	logic [WIDTH-1:0] count;
	logic msb_toggle;
	modport core (input tick, output count, output msb_toggle);
	modport ctrl (output tick, input count, input msb_toggle);
endinterface // timer_core_if

//--- src/pm_timer_counter.sv
// Free-running up-counter with a top-bit change pulse
`timescale 1ns/1ns
module pm_timer_counter
	import pm_timer_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH
) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Master reset, async, active low
	timer_core_if.core core // Tick in, count and toggle out
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;
	logic msb_toggle;
	logic next_msb_toggle;

	always_comb begin
		next_count = count;
		next_msb_toggle = 1'b0;
		if (core.tick) begin
			next_count = count + {{(WIDTH-1){1'b0}}, 1'b1}; // RULE1
			// Top bit flips on 0->1 and on the 1->0 wrap alike
			next_msb_toggle = next_count[WIDTH-1] ^ count[WIDTH-1]; // RULE5
		end
	end

	// No tick means the count simply holds until the reference returns
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= COUNT_RESET[WIDTH-1:0]; // RULE3
			msb_toggle <= 1'b0;
		end else begin
			count <= next_count; // RULE4
			msb_toggle <= next_msb_toggle;
		end
	end

	assign core.count = count;
	assign core.msb_toggle = msb_toggle;
endmodule // pm_timer_counter

//--- src/pm_timer.sv
// Power management timer: reference sampling, count bytes, toggle flag and routing
//
// Function
// RULE1 - 24-bit counter advances once per reference clock cycle.
// RULE2 - Counting happens only in the working power state.
// RULE3 - Reset clears the counter; it then runs while the reference toggles.
// RULE4 - Reference stop holds the count; restart resumes from it unless reset.
// RULE5 - Every change of counter bit 23, either way, sets the toggle flag.
// RULE6 - Flag set with the enable on raises a control interrupt request; here only with the route bit set, else a management request with smi_enable set.
// RULE7 - Byte at base plus 8 reads count bits 7..0.
// RULE8 - Byte at base plus 9 reads count bits 15..8.
// RULE9 - Byte at base plus A reads count bits 23..16.
// RULE10 - Count bytes are read-only, live, and writes leave the counter alone.
// RULE11 - Events go to control interrupt if route bit set, else management interrupt.
// RULE12 - Flag holds until cleared; request stays while flag and enable are set.
`timescale 1ns/1ns
module pm_timer
	import pm_timer_pkg::*;
#(
	parameter int WIDTH = COUNT_WIDTH,
	parameter int SYNC_STAGES = 2
) (
	input wire logic clk, // 25 MHz system clock
	input wire logic rst_n, // Master reset, async, active low
	input wire logic reference_clock_input, // Timer reference pin
	input wire logic working_state, // High while system is in working state
	input wire logic [15:0] pm_io_base_config, // Power management I/O base
	input wire logic [15:0] io_addr, // I/O cycle address
	input wire logic io_rd, // One-cycle read strobe
	input wire logic io_wr, // One-cycle write strobe
	input wire logic [7:0] io_wdata, // Write data, unused by count bytes
	input wire logic timer_irq_enable, // Timer interrupt enable
	input wire logic event_route_select, // 1 routes events to control interrupt
	input wire logic smi_enable, // Management interrupt enable
	input wire logic flag_clear, // One-cycle clear of the toggle flag
	output logic [7:0] io_rdata, // Read data, valid with io_rdata_valid
	output logic io_rdata_valid, // One-cycle pulse for a claimed read
	output logic timer_msb_toggle_flag, // Sticky top-bit toggle status
	output logic sci_request, // Control interrupt request, level
	output logic smi_request, // Management interrupt request, level
	output logic [WIDTH-1:0] timer_count_value // Live count
);
	timer_core_if #(.WIDTH(WIDTH)) core_bus ();

	// Pin synchronisers, one chain per pin
	logic [SYNC_COUNT-1:0] pin_raw;
	logic [SYNC_COUNT-1:0] pin_sync;
	assign pin_raw[SYNC_REF] = reference_clock_input;
	assign pin_raw[SYNC_WORK] = working_state;

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_COUNT; gi++) begin : g_sync
			logic [SYNC_STAGES-1:0] stage;
			logic [SYNC_STAGES-1:0] next_stage;
			always_comb begin
				next_stage = {stage[SYNC_STAGES-2:0], pin_raw[gi]};
			end
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					stage <= '0;
				end else begin
					stage <= next_stage;
				end
			end
			assign pin_sync[gi] = stage[SYNC_STAGES-1];
		end
	endgenerate

	// Edge detect on the synchronised reference only
	logic ref_prev;
	logic next_ref_prev;
	logic tick;

	always_comb begin
		next_ref_prev = pin_sync[SYNC_REF];
		// Rising edge in working state; a stopped reference gives no edge
		tick = pin_sync[SYNC_REF] & ~ref_prev & pin_sync[SYNC_WORK]; // RULE2
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_prev <= 1'b0;
		end else begin
			ref_prev <= next_ref_prev;
		end
	end

	assign core_bus.tick = tick; // RULE1

	pm_timer_counter #(
		.WIDTH(WIDTH)
	) u_counter (
		.clk(clk),
		.rst_n(rst_n),
		.core(core_bus.core)
	);

	// Address decode relative to the programmable base
	logic [15:0] rel_addr;
	logic hit_low;
	logic hit_mid;
	logic hit_high;
	logic [7:0] next_io_rdata;
	logic next_io_rdata_valid;

	always_comb begin
		rel_addr = io_addr - pm_io_base_config;
		hit_low = (rel_addr == OFFSET_COUNT_LOW);
		hit_mid = (rel_addr == OFFSET_COUNT_MID);
		hit_high = (rel_addr == OFFSET_COUNT_HIGH);
		next_io_rdata = BYTE_RESET;
		next_io_rdata_valid = 1'b0;
		// Writes never reach the counter; no byte snapshot, so multi-byte reads may tear
		if (io_rd && !io_wr) begin // RULE10
			if (hit_low) begin
				next_io_rdata = core_bus.count[COUNT_LOW_LSB +: BYTE_WIDTH]; // RULE7
				next_io_rdata_valid = 1'b1;
			end else if (hit_mid) begin
				next_io_rdata = core_bus.count[COUNT_MID_LSB +: BYTE_WIDTH]; // RULE8
				next_io_rdata_valid = 1'b1;
			end else if (hit_high) begin
				next_io_rdata = core_bus.count[COUNT_HIGH_LSB +: BYTE_WIDTH]; // RULE9
				next_io_rdata_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata <= BYTE_RESET;
			io_rdata_valid <= 1'b0;
		end else begin
			io_rdata <= next_io_rdata;
			io_rdata_valid <= next_io_rdata_valid;
		end
	end

	// Sticky flag and interrupt routing
	logic next_flag;
	logic next_sci;
	logic next_smi;
	logic timer_event;

	always_comb begin
		// Set beats a clear landing in the same cycle
		next_flag = core_bus.msb_toggle | (timer_msb_toggle_flag & ~flag_clear); // RULE5 RULE12
		timer_event = next_flag & timer_irq_enable; // RULE6
		next_sci = timer_event & event_route_select; // RULE11
		next_smi = timer_event & ~event_route_select & smi_enable; // RULE11
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timer_msb_toggle_flag <= 1'b0;
			sci_request <= 1'b0;
			smi_request <= 1'b0;
			timer_count_value <= COUNT_RESET[WIDTH-1:0];
		end else begin
			timer_msb_toggle_flag <= next_flag; // RULE12
			sci_request <= next_sci; // RULE6
			smi_request <= next_smi;
			timer_count_value <= core_bus.count;
		end
	end
endmodule // pm_timer

//--- testbench/ref_source.sv
// Reference clock source for the timer, standing still when stopped
`timescale 1ns/1ns
module ref_source (
	input wire logic clk, // Bench clock
	input wire logic run, // Start new periods while high
	output logic ref_out, // Reference clock, low when stopped
	output int edges // Rising edges produced
);
	int ph = 0;
	initial ref_out = 1'b0;
	initial edges = 0;
	// Seven clocks a period; a started period always completes
	always @(posedge clk) begin
		if (run || ph != 0) begin
			ref_out <= (ph < 3);
			ph <= (ph + 1) % 7;
			if (ph == 0) edges <= edges + 1;
		end
	end
endmodule // ref_source

//--- testbench/pm_timer_asserts.sv
// Port assertions for the power management timer
`timescale 1ns/1ns
module pm_timer_asserts import pm_timer_pkg::*; #(parameter int WIDTH = COUNT_WIDTH) (
	input wire logic clk, // System clock
	input wire logic rst_n, // Master reset, active low
	input wire logic working_state, // Working state pin
	input wire logic io_rd, // Read strobe
	input wire logic io_wr, // Write strobe
	input wire logic timer_irq_enable, // Timer interrupt enable
	input wire logic event_route_select, // Route select
	input wire logic smi_enable, // Management interrupt enable
	input wire logic flag_clear, // Flag clear pulse
	input wire logic io_rdata_valid, // Read answer strobe
	input wire logic timer_msb_toggle_flag, // Sticky toggle flag
	input wire logic sci_request, // Control interrupt request
	input wire logic smi_request, // Management interrupt request
	input wire logic [15:0] pm_io_base_config, // I/O base
	input wire logic [15:0] io_addr, // I/O address
	input wire logic [7:0] io_rdata, // Read data
	input wire logic [WIDTH-1:0] timer_count_value // Live count
);
	logic [15:0] off;
	logic rd;
	logic hit;
	logic [WIDTH-1:0] c;
	assign off = io_addr - pm_io_base_config;
	assign rd = io_rd && !io_wr;
	assign hit = rd && off inside {OFFSET_COUNT_LOW, OFFSET_COUNT_MID, OFFSET_COUNT_HIGH};
	assign c = timer_count_value;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_lo; rd && off == OFFSET_COUNT_LOW |=> io_rdata_valid && io_rdata == c[7:0]; endproperty
	a_lo: assert property (p_lo) else $error("low byte wrong");
	property p_mid; rd && off == OFFSET_COUNT_MID |=> io_rdata_valid && io_rdata == c[15:8]; endproperty
	a_mid: assert property (p_mid) else $error("mid byte wrong");
	property p_hi; rd && off == OFFSET_COUNT_HIGH |=> io_rdata_valid && io_rdata == c[23:16]; endproperty
	a_hi: assert property (p_hi) else $error("high byte wrong");
	property p_no; !hit |=> !io_rdata_valid && io_rdata == 8'h00; endproperty
	a_no: assert property (p_no) else $error("unclaimed access answered");
	property p_step; c == $past(c) || c == $past(c) + 1'b1; endproperty
	a_step: assert property (p_step) else $error("count jumped");
	property p_idle; !working_state [*6] |=> $stable(c); endproperty
	a_idle: assert property (p_idle) else $error("count moved outside working state");
	property p_tog; c[WIDTH-1] != $past(c[WIDTH-1]) |-> timer_msb_toggle_flag; endproperty
	a_tog: assert property (p_tog) else $error("top bit change not flagged");
	property p_sci; sci_request == (timer_msb_toggle_flag && $past(timer_irq_enable)
		&& $past(event_route_select)); endproperty
	a_sci: assert property (p_sci) else $error("control request wrong");
	property p_smi; smi_request == (timer_msb_toggle_flag && $past(timer_irq_enable)
		&& !$past(event_route_select) && $past(smi_enable)); endproperty
	a_smi: assert property (p_smi) else $error("management request wrong");
	property p_hold; timer_msb_toggle_flag && !flag_clear |=> timer_msb_toggle_flag; endproperty
	a_hold: assert property (p_hold) else $error("flag dropped without clear");
	property p_clr; flag_clear |=> !timer_msb_toggle_flag
		|| (c[WIDTH-1] != $past(c[WIDTH-1])); endproperty
	a_clr: assert property (p_clr) else $error("flag survived clear");
	cover property (flag_clear && timer_irq_enable);
	cover property (rd && off == OFFSET_COUNT_HIGH);
	cover property (!working_state [*6]);
	cover property (io_wr && off == OFFSET_COUNT_LOW);
endmodule // pm_timer_asserts
bind pm_timer pm_timer_asserts #(.WIDTH(WIDTH)) chk (.*);

//--- testbench/pm_timer_test.sv
// Self-checking bench for the power management timer
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module pm_timer_test;
	import pm_timer_pkg::*;
	logic clk = 0, rst_n = 0, working_state = 0, io_rd = 0, io_wr = 0, run = 0, flag_clear = 0;
	logic timer_irq_enable = 1, event_route_select = 0, smi_enable = 1, reference_clock_input;
	logic [15:0] pm_io_base_config = 16'h0000, io_addr = 16'h0000;
	logic [7:0] io_wdata = 8'h00, io_rdata, got_e;
	logic io_rdata_valid, timer_msb_toggle_flag, sci_request, smi_request;
	logic [23:0] timer_count_value, exp_count = 24'h000000;
	logic [7:0] q[$];
	int n_mismatch = 0, check_count = 0, edges;
	always #20 clk = ~clk;
	ref_source src (.clk(clk), .run(run), .ref_out(reference_clock_input), .edges(edges));
	pm_timer dut (.*);
	task automatic access(input logic [15:0] off, input logic wr, input logic [7:0] e);
		@(posedge clk);
		io_rd <= ~wr;
		io_wr <= wr;
		io_addr <= pm_io_base_config + off;
		io_wdata <= 8'($urandom);
		if (!wr && off inside {[16'h0008:16'h000A]}) q.push_back(e);
		@(posedge clk);
		io_rd <= 1'b0;
		io_wr <= 1'b0;
	endtask
	task automatic read_all();
		access(OFFSET_COUNT_LOW, 0, exp_count[7:0]);
		access(OFFSET_COUNT_MID, 0, exp_count[15:8]);
		access(OFFSET_COUNT_HIGH, 0, exp_count[23:16]);
	endtask
	// Reference runs only after the working level has passed the synchroniser
	task automatic phase(input logic work, input int n);
		int e0;
		working_state <= work;
		repeat (4) @(posedge clk);
		e0 = edges;
		run <= 1'b1;
		repeat (n) @(posedge clk);
		run <= 1'b0;
		repeat (16) @(posedge clk);
		if (work) exp_count = exp_count + 24'(edges - e0);
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) if (io_rdata_valid === 1'b1) begin
		if (q.size() == 0) `CHK("unclaimed valid", 1'b0, 1'b1)
		else begin
			got_e = q.pop_front();
			`CHK("read byte", got_e, io_rdata)
		end
	end
	initial begin
		#400000;
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(40));
		pm_io_base_config <= 16'($urandom) & 16'hFFF0;
		event_route_select <= 1'($urandom);
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		phase(1, 20 + $urandom % 40);
		read_all();
		timer_irq_enable <= 1'($urandom);
		smi_enable <= 1'($urandom);
		flag_clear <= 1'b1;
		@(posedge clk);
		flag_clear <= 1'b0;
		access(OFFSET_COUNT_LOW, 1, 8'h00);
		access(16'h000B, 0, 8'h00);
		read_all();
		phase(0, 50);
		read_all();
		phase(1, 30);
		read_all();
		repeat (2) @(posedge clk);
		`CHK("toggle flag", 1'b0, timer_msb_toggle_flag)
		`CHK("live count", exp_count, timer_count_value)
		`CHK("control request", 1'b0, sci_request)
		`CHK("management request", 1'b0, smi_request)
		`CHK("unanswered reads", 0, q.size())
		finish_test();
	end
endmodule // pm_timer_test
